// File: hw/clock_gen_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH
`define CG_SC_OFFSET 12'h000
`define CG_CTL_OFFSET 12'h004
`define CG_IRQ_STAT_OFFSET 12'h008
`define CG_IRQ_MASK_OFFSET 12'h00c
`define CG_SC_LOSS_OF_LOCK_STICKY_BIT 7
`define CG_SC_FINE_TRIM_BIT 0
`define CG_CTL_LOOP_BIT 0
`define CG_CTL_REF_BIT 1
`define CG_CTL_CLOCK_SOURCE_SELECT_LSB 2
`define CG_CTL_REFERENCE_DIVIDER_LSB 4
`define CG_CTL_VCO_MULTIPLIER_SELECT_LSB 7
`define CG_CTL_TRIM_LSB 11
`define CG_CTL_LOCK_LOSS_IRQ_ENABLE_BIT 19
`define CG_CTL_OSCREQ_BIT 20
`define CG_CTL_EXTEN_BIT 21
`define CG_CTL_LP_BIT 22
`define CG_CTL_WIDTH 23
`define CG_CTL_RESET 23'h000002
`define CG_IRQ_WIDTH 3
`define CG_IRQ_LOCKED_BIT 0
`define CG_IRQ_OSC_BIT 1
`define CG_IRQ_LOST_BIT 2
`define CG_LOCK_SETTLE_CYCLES 16
`define CG_SYNC_WIDTH 9
`endif

// File: hw/clock_gen_pkg.sv
// types shared by the clock generator status and control logic
package clock_gen_pkg;
  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b00,
    LOCK_SETTLE = 2'b01,
    LOCK_HELD = 2'b11
  } lock_state_t;
  typedef enum logic [1:0] {
    MODE_FLL = 2'b00,
    MODE_INT_REF = 2'b01,
    MODE_EXT_REF = 2'b10,
    MODE_PLL = 2'b11
  } clock_mode_t;
endpackage : clock_gen_pkg

// File: hw/clock_gen_status_control.sv
// clock generator status and control register logic with apb slave
// Behaviour
// - set sticky loss-of-lock when locked loop drifts
// - write one clears sticky flag, zero ignored
// - loss-of-lock request gated by its enable
// - lock bit shows lock; off with both loops
// - config change while locked clears lock
// - stop entry clears lock until reacquired
// - bypassed low-power modes hold lock cleared
// - loop status follows select after synchronization
// - reference status follows select after synchronization
// - clock mode field encodes selected output
// - clock mode changes only after synchronization
// - oscillator ready set after initialization cycles
// - oscillator ready clears on request removal
// - fine trim bit drives smallest period step
// - irq enable acts only while flag set
`timescale 1ns/1ps
`include "clock_gen_regs.svh"
module clock_gen_status_control #(
  parameter int LOCK_SETTLE_CYCLES = `CG_LOCK_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status from loop, oscillator and clock-switch domains
  input wire logic loop_in_tolerance,
  input wire logic osc_init_done,
  input wire logic fll_enabled,
  input wire logic pll_enabled,
  input wire logic stop_active,
  input wire logic loop_select_ack,
  input wire logic ref_source_ack,
  input wire logic [1:0] clock_mode_ack,
  // control to the clock generator
  output logic loop_select,
  output logic ref_source_select,
  output logic [1:0] clock_source_select,
  output logic [2:0] reference_divider,
  output logic [3:0] vco_multiplier_select,
  output logic [7:0] coarse_trim,
  output logic fine_trim,
  output logic oscillator_request,
  output logic external_reference_enable,
  output logic low_power_select,
  output logic lock_loss_irq_enable,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [`CG_SYNC_WIDTH-1:0] sync_in;
  logic [`CG_SYNC_WIDTH-1:0] sync_meta;
  logic [`CG_SYNC_WIDTH-1:0] sync_out;
  assign sync_in = {clock_mode_ack, ref_source_ack, loop_select_ack, stop_active,
                    pll_enabled, fll_enabled, osc_init_done, loop_in_tolerance};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      sync_meta <= sync_in;
      sync_out <= sync_meta;
    end
  end

  wire tol_s = sync_out[0];
  wire osc_done_s = sync_out[1];
  wire fll_on_s = sync_out[2];
  wire pll_on_s = sync_out[3];
  wire stop_s = sync_out[4];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [`CG_CTL_WIDTH-1:0] ctl;
  logic [`CG_IRQ_WIDTH-1:0] irq_stat;
  logic [`CG_IRQ_WIDTH-1:0] irq_mask;
  logic loss_of_lock_sticky;
  logic osc_ready;
  logic stop_d;
  logic [31:0] next_prdata;

  wire sel_sc = paddr == `CG_SC_OFFSET;
  wire sel_ctl = paddr == `CG_CTL_OFFSET;
  wire sel_stat = paddr == `CG_IRQ_STAT_OFFSET;
  wire sel_mask = paddr == `CG_IRQ_MASK_OFFSET;
  wire mapped = sel_sc | sel_ctl | sel_stat | sel_mask;
  wire setup = psel & !penable;
  wire access = psel & penable;
  wire wr = access & pwrite & mapped;
  wire rd_stat = access & !pwrite & sel_stat;
  wire wr_sc = wr & sel_sc;
  wire wr_ctl = wr & sel_ctl;
  wire [`CG_CTL_WIDTH-1:0] wctl = pwdata[`CG_CTL_WIDTH-1:0];

  // zero wait states: data was captured in setup, answer in access
  assign pready = 1'b1;
  assign pslverr = access & !mapped;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  assign loop_select = ctl[`CG_CTL_LOOP_BIT];
  assign ref_source_select = ctl[`CG_CTL_REF_BIT];
  assign clock_source_select = ctl[`CG_CTL_CLOCK_SOURCE_SELECT_LSB +: 2];
  assign reference_divider = ctl[`CG_CTL_REFERENCE_DIVIDER_LSB +: 3];
  assign vco_multiplier_select = ctl[`CG_CTL_VCO_MULTIPLIER_SELECT_LSB +: 4];
  assign coarse_trim = ctl[`CG_CTL_TRIM_LSB +: 8];
  assign lock_loss_irq_enable = ctl[`CG_CTL_LOCK_LOSS_IRQ_ENABLE_BIT];
  assign oscillator_request = ctl[`CG_CTL_OSCREQ_BIT];
  assign external_reference_enable = ctl[`CG_CTL_EXTEN_BIT];
  assign low_power_select = ctl[`CG_CTL_LP_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl <= `CG_CTL_RESET;
    else if (wr_ctl)
      ctl <= wctl;
  end

  // ----------------------------------------------------------------
  // synchronised status
  // ----------------------------------------------------------------
  // these follow the clock-switch acknowledge, never the write itself
  wire loop_select_status = sync_out[5];
  wire ref_source_status = sync_out[6];
  wire [1:0] clock_mode_status = sync_out[8:7];

  wire int_fll = ref_source_status & !loop_select_status;
  wire bypass_mode = clock_mode_status == clock_gen_pkg::MODE_INT_REF ||
                     clock_mode_status == clock_gen_pkg::MODE_EXT_REF;
  wire bypass_lp = bypass_mode & low_power_select;
  wire ext_mode = !ref_source_status;
  wire detect_on = fll_on_s | pll_on_s;

  // ----------------------------------------------------------------
  // lock tracking
  // ----------------------------------------------------------------
  clock_gen_pkg::lock_state_t lock_state;
  clock_gen_pkg::lock_state_t next_lock_state;
  logic [15:0] settle_cnt;

  wire cfg_change = wr_ctl & (
      (wctl[`CG_CTL_REF_BIT] != ctl[`CG_CTL_REF_BIT]) |
      (wctl[`CG_CTL_LOOP_BIT] != ctl[`CG_CTL_LOOP_BIT]) |
      (wctl[`CG_CTL_REFERENCE_DIVIDER_LSB +: 3] != ctl[`CG_CTL_REFERENCE_DIVIDER_LSB +: 3]) |
      (int_fll & (wctl[`CG_CTL_TRIM_LSB +: 8] != ctl[`CG_CTL_TRIM_LSB +: 8])) |
      (loop_select_status & ext_mode &
       (wctl[`CG_CTL_VCO_MULTIPLIER_SELECT_LSB +: 4] != ctl[`CG_CTL_VCO_MULTIPLIER_SELECT_LSB +: 4])));
  wire stop_rise = stop_s & !stop_d;
  wire disturb = cfg_change | stop_rise | stop_s | bypass_lp | !detect_on;
  wire lock = lock_state == clock_gen_pkg::LOCK_HELD;
  wire lock_lost = lock & !tol_s & !disturb;
  wire settle_done = settle_cnt == 16'(LOCK_SETTLE_CYCLES - 1);

  always_comb
  begin
    next_lock_state = lock_state;
    if (disturb)
      next_lock_state = clock_gen_pkg::LOCK_IDLE;
    else
    begin
      case (lock_state)
        clock_gen_pkg::LOCK_IDLE:
          if (tol_s)
            next_lock_state = clock_gen_pkg::LOCK_SETTLE;
        clock_gen_pkg::LOCK_SETTLE:
          if (!tol_s)
            next_lock_state = clock_gen_pkg::LOCK_IDLE;
          else if (settle_done)
            next_lock_state = clock_gen_pkg::LOCK_HELD;
        clock_gen_pkg::LOCK_HELD:
          if (!tol_s)
            next_lock_state = clock_gen_pkg::LOCK_IDLE;
        default:
          next_lock_state = clock_gen_pkg::LOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_state <= clock_gen_pkg::LOCK_IDLE;
      settle_cnt <= 16'h0000;
      stop_d <= 1'b0;
    end
    else
    begin
      lock_state <= next_lock_state;
      settle_cnt <= (lock_state == clock_gen_pkg::LOCK_SETTLE) ? settle_cnt + 16'h0001 : 16'h0000;
      stop_d <= stop_s;
    end
  end

  // ----------------------------------------------------------------
  // status and control register
  // ----------------------------------------------------------------
  // a new loss in the same cycle as the clearing write keeps the flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loss_of_lock_sticky <= 1'b0;
    else if (lock_lost)
      loss_of_lock_sticky <= 1'b1;
    else if (wr_sc & pwdata[`CG_SC_LOSS_OF_LOCK_STICKY_BIT])
      loss_of_lock_sticky <= 1'b0;
  end

  // only the fine trim bit is writable here; bits 6..1 are hardware state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fine_trim <= 1'b0;
    else if (wr_sc)
      fine_trim <= pwdata[`CG_SC_FINE_TRIM_BIT];
  end

  wire osc_set = (external_reference_enable | ext_mode) & oscillator_request & osc_done_s;
  wire osc_clr = !oscillator_request | (!ext_mode & !external_reference_enable);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_ready <= 1'b0;
    else if (osc_clr)
      osc_ready <= 1'b0;
    else if (osc_set)
      osc_ready <= 1'b1;
  end

  wire [7:0] sc_value = {loss_of_lock_sticky, lock, loop_select_status, ref_source_status,
                         clock_mode_status, osc_ready, fine_trim};

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`CG_IRQ_WIDTH-1:0] irq_set;
  logic [`CG_IRQ_WIDTH-1:0] irq_clr;
  logic osc_ready_d;

  assign irq_set = {lock_lost, osc_ready & !osc_ready_d,
                    next_lock_state == clock_gen_pkg::LOCK_HELD && !lock};
  // read clears only what was captured, so a fresh event survives
  assign irq_clr = rd_stat ? prdata[`CG_IRQ_WIDTH-1:0] : '0;
  wire lol_request = loss_of_lock_sticky & lock_loss_irq_enable;
  assign irq = lol_request | (|(irq_stat & irq_mask));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      osc_ready_d <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      osc_ready_d <= osc_ready;
      if (wr & sel_mask)
        irq_mask <= pwdata[`CG_IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (sel_sc)
      next_prdata[7:0] = sc_value;
    else if (sel_ctl)
      next_prdata[`CG_CTL_WIDTH-1:0] = ctl;
    else if (sel_stat)
      next_prdata[`CG_IRQ_WIDTH-1:0] = irq_stat;
    else if (sel_mask)
      next_prdata[`CG_IRQ_WIDTH-1:0] = irq_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= next_prdata;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_lol_set;
    @(posedge pclk) disable iff (!presetn)
    lock & !tol_s & !disturb |=> loss_of_lock_sticky & !lock;
  endproperty
  a_lol_set: assert property (p_lol_set) else $error("loss of lock not flagged");
  property p_lol_w1c;
    @(posedge pclk) disable iff (!presetn)
    wr_sc & pwdata[7] & !lock_lost |=> !loss_of_lock_sticky;
  endproperty
  a_lol_w1c: assert property (p_lol_w1c) else $error("write one did not clear flag");
  property p_lol_w0;
    @(posedge pclk) disable iff (!presetn)
    wr_sc & !pwdata[7] & loss_of_lock_sticky |=> loss_of_lock_sticky;
  endproperty
  a_lol_w0: assert property (p_lol_w0) else $error("write zero changed flag");
  property p_irq_lol;
    @(posedge pclk) disable iff (!presetn)
    loss_of_lock_sticky & lock_loss_irq_enable |-> irq;
  endproperty
  a_irq_lol: assert property (p_irq_lol) else $error("enabled loss of lock gave no irq");
  property p_detect_off;
    @(posedge pclk) disable iff (!presetn)
    !fll_on_s & !pll_on_s |=> !sc_value[6];
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("lock with both loops off");
  property p_cfg_clear;
    @(posedge pclk) disable iff (!presetn)
    cfg_change |=> !lock ##1 !lock;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("config change kept lock");
  property p_stop_clear;
    @(posedge pclk) disable iff (!presetn)
    stop_rise |=> !lock;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop entry kept lock");
  property p_bypass_hold;
    @(posedge pclk) disable iff (!presetn)
    bypass_lp [*2] |-> !lock;
  endproperty
  a_bypass_hold: assert property (p_bypass_hold) else $error("lock in low-power bypass");
  property p_loop_sync;
    @(posedge pclk) disable iff (!presetn)
    ##2 sc_value[5] == $past(loop_select_ack, 2);
  endproperty
  a_loop_sync: assert property (p_loop_sync) else $error("loop status not two-stage synced");
  property p_mode_sync;
    @(posedge pclk) disable iff (!presetn)
    ##2 sc_value[3:2] == $past(clock_mode_ack, 2);
  endproperty
  a_mode_sync: assert property (p_mode_sync) else $error("clock mode status mismatch");
  property p_osc_clear;
    @(posedge pclk) disable iff (!presetn)
    !oscillator_request |=> !osc_ready;
  endproperty
  a_osc_clear: assert property (p_osc_clear) else $error("osc ready without request");
endmodule : clock_gen_status_control

// File: test/clock_gen_status_control_test.sv
// self-checking bench for the clock generator status and control registers
`timescale 1ns/1ps
`include "clock_gen_regs.svh"
module clock_gen_status_control_test;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic loop_in_tolerance = 1'b0;
  logic osc_init_done = 1'b0;
  logic fll_enabled = 1'b0;
  logic pll_enabled = 1'b0;
  logic stop_active = 1'b0;
  logic loop_select_ack = 1'b0;
  logic ref_source_ack = 1'b1;
  logic [1:0] clock_mode_ack = 2'h0;
  logic [1:0] clock_source_select;
  logic fine_trim;
  logic loop_select;
  logic ref_source_select;
  logic [2:0] reference_divider;
  logic [3:0] vco_multiplier_select;
  logic [7:0] coarse_trim;
  logic oscillator_request;
  logic external_reference_enable;
  logic low_power_select;
  logic lock_loss_irq_enable;
  logic irq;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic e;

  always #10 pclk = ~pclk;

  // short settle count keeps lock waits brief
  clock_gen_status_control #(.LOCK_SETTLE_CYCLES(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .loop_in_tolerance, .osc_init_done, .fll_enabled, .pll_enabled,
    .stop_active, .loop_select_ack, .ref_source_ack, .clock_mode_ack,
    .loop_select, .ref_source_select, .clock_source_select, .reference_divider,
    .vco_multiplier_select, .coarse_trim, .fine_trim, .oscillator_request,
    .external_reference_enable, .low_power_select, .lock_loss_irq_enable, .irq
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task results;
    if (n_fail == 0 && cmp_count > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_fail++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rc

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  initial
  begin
    #400000;
    n_fail++;
    results();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reference status needs the two synchroniser stages before it reads back
    idle(4);
    rc(`CG_SC_OFFSET, 32'h10);
    rc(`CG_CTL_OFFSET, 32'h2);
    chk({31'h0, e}, 32'h0);
    rc(`CG_IRQ_MASK_OFFSET, 32'h0);
    rc(`CG_IRQ_STAT_OFFSET, 32'h0);
    rc(12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    // every control field reaches its output
    wr(`CG_CTL_OFFSET, 32'h0055aa55);
    rc(`CG_CTL_OFFSET, 32'h0055aa55);
    chk({9'h0, low_power_select, external_reference_enable, oscillator_request,
         lock_loss_irq_enable, coarse_trim, vco_multiplier_select, reference_divider,
         clock_source_select, ref_source_select, loop_select}, 32'h0055aa55);
    wr(`CG_CTL_OFFSET, 32'h2);
    // status bits ignore writes, fine trim is kept
    wr(`CG_SC_OFFSET, 32'h7f);
    rc(`CG_SC_OFFSET, 32'h11);
    chk({31'h0, fine_trim}, 32'h1);
    wr(`CG_SC_OFFSET, 32'h0);
    rc(`CG_SC_OFFSET, 32'h10);
    // every clock mode code; status waits for the switch to answer
    for (int m = 0; m < 4; m++)
    begin
      wr(`CG_CTL_OFFSET, 32'h2 | (m << 2));
      rc(`CG_SC_OFFSET, {26'h0, loop_select_ack, ref_source_ack, clock_mode_ack, 2'h0});
      chk({30'h0, clock_source_select}, m);
      clock_mode_ack <= m[1:0];
      loop_select_ack <= m[0];
      ref_source_ack <= ~m[1];
      idle(4);
      rc(`CG_SC_OFFSET, {26'h0, m[0], ~m[1], m[1:0], 2'h0});
    end
    clock_mode_ack <= 2'h0;
    loop_select_ack <= 1'b0;
    ref_source_ack <= 1'b1;
    wr(`CG_CTL_OFFSET, 32'h2);
    // lock, then loss with the enable on
    fll_enabled <= 1'b1;
    loop_in_tolerance <= 1'b1;
    idle(14);
    rc(`CG_SC_OFFSET, 32'h50);
    rc(`CG_IRQ_STAT_OFFSET, 32'h1);
    rc(`CG_IRQ_STAT_OFFSET, 32'h0);
    wr(`CG_CTL_OFFSET, 32'h80002);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    loop_in_tolerance <= 1'b0;
    idle(6);
    chk({31'h0, irq}, 32'h1);
    rc(`CG_SC_OFFSET, 32'h90);
    wr(`CG_SC_OFFSET, 32'h0);
    rc(`CG_SC_OFFSET, 32'h90);
    wr(`CG_CTL_OFFSET, 32'h2);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    wr(`CG_SC_OFFSET, 32'h80);
    rc(`CG_SC_OFFSET, 32'h10);
    wr(`CG_IRQ_MASK_OFFSET, 32'h4);
    idle(1);
    chk({31'h0, irq}, 32'h1);
    rc(`CG_IRQ_STAT_OFFSET, 32'h4);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    wr(`CG_IRQ_MASK_OFFSET, 32'h0);
    // divider change while locked drops lock without loss flag
    loop_in_tolerance <= 1'b1;
    idle(14);
    wr(`CG_CTL_OFFSET, 32'h12);
    rc(`CG_SC_OFFSET, 32'h10);
    idle(14);
    rc(`CG_SC_OFFSET, 32'h50);
    wr(`CG_CTL_OFFSET, 32'h2);
    idle(14);
    // coarse trim change in the internal loop mode drops lock
    wr(`CG_CTL_OFFSET, 32'h802);
    rc(`CG_SC_OFFSET, 32'h10);
    wr(`CG_CTL_OFFSET, 32'h2);
    idle(14);
    // stop entry
    stop_active <= 1'b1;
    idle(16);
    rc(`CG_SC_OFFSET, 32'h10);
    stop_active <= 1'b0;
    idle(14);
    rc(`CG_SC_OFFSET, 32'h50);
    // bypassed low-power internal mode
    wr(`CG_CTL_OFFSET, 32'h400006);
    clock_mode_ack <= 2'h1;
    idle(16);
    rc(`CG_SC_OFFSET, 32'h14);
    clock_mode_ack <= 2'h0;
    wr(`CG_CTL_OFFSET, 32'h2);
    idle(14);
    rc(`CG_SC_OFFSET, 32'h50);
    fll_enabled <= 1'b0;
    idle(6);
    rc(`CG_SC_OFFSET, 32'h10);
    // lock through the second loop, then a multiplier change in external loop mode
    pll_enabled <= 1'b1;
    loop_select_ack <= 1'b1;
    ref_source_ack <= 1'b0;
    idle(14);
    rc(`CG_SC_OFFSET, 32'h60);
    wr(`CG_CTL_OFFSET, 32'h82);
    rc(`CG_SC_OFFSET, 32'h20);
    pll_enabled <= 1'b0;
    loop_select_ack <= 1'b0;
    ref_source_ack <= 1'b1;
    wr(`CG_CTL_OFFSET, 32'h2);
    idle(6);
    // oscillator ready set and both clear paths
    wr(`CG_CTL_OFFSET, 32'h300002);
    osc_init_done <= 1'b1;
    idle(6);
    rc(`CG_SC_OFFSET, 32'h12);
    wr(`CG_CTL_OFFSET, 32'h200002);
    rc(`CG_SC_OFFSET, 32'h10);
    wr(`CG_CTL_OFFSET, 32'h100002);
    idle(4);
    rc(`CG_SC_OFFSET, 32'h10);
    ref_source_ack <= 1'b0;
    idle(6);
    rc(`CG_SC_OFFSET, 32'h02);
    ref_source_ack <= 1'b1;
    idle(6);
    rc(`CG_SC_OFFSET, 32'h10);
    results();
  end
endmodule : clock_gen_status_control_test
